/* File: src/gki_pkg.sv */
// package: register map, field layout and timing for the gpio/key irq block
package gki_pkg;
  localparam logic [7:0] ADDR_FUNC_SELECT  = 8'h17;
  localparam logic [7:0] ADDR_DIRECTION    = 8'h18;
  localparam logic [7:0] ADDR_LEVEL        = 8'h19;
  localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h1b;
  localparam logic [7:0] ADDR_IRQ_FLAGS    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_POLARITY = 8'h1d;
  localparam logic [7:0] ADDR_FILTER_BYP   = 8'h1e;
  localparam logic [7:0] ADDR_WEAK_HIGH    = 8'h1f;
  localparam logic [7:0] ADDR_KEYPRESS_LOW = 8'h20;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam int         LINE_COUNT        = 8;
  // debounce: input must hold steady this long before it is accepted
  localparam int         DEBOUNCE_NS       = 1000;
  localparam int         CLK_PERIOD_NS     = 25;
  localparam int         DEBOUNCE_CYCLES   =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         DEB_W             = 6;
  typedef enum logic [1:0] {
    GKI_RD_IDLE  = 2'b00,
    GKI_RD_ARMED = 2'b01
  } gki_rd_state_t;
endpackage

/* File: src/gki_debounce.sv */
// per-line debounce filter with bypass
`timescale 1ns/10ps
module gki_debounce
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic raw,
  input  wire logic bypass,
  output logic      level
);
  logic [gki_pkg::DEB_W-1:0] count;
  logic                      filtered;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count    <= '0;
      filtered <= 1'b0;
    end
    else if (raw == filtered)
      count <= '0;
    else if (count == gki_pkg::DEB_W'(gki_pkg::DEBOUNCE_CYCLES - 1))
    begin
      filtered <= raw;
      count    <= '0;
    end
    else
      count <= count + 1'b1;
  end

  assign level = bypass ? raw : filtered;
endmodule

/* File: src/gki_core.sv */
// gpio line interrupt, input conditioning and key-press flag registers
// Notes on behaviour
// - interrupt enable bit n lets input line n drive the interrupt low.
// - enable bit zero: line n never causes an interrupt.
// - status bit n sets on an interrupt condition on line n.
// - line status bits clear only after the host reads them twice.
// - level bit zero: low input is the interrupt condition.
// - level bit one: high input is the interrupt condition.
// - debounce bit zero (reset) keeps filtering on.
// - debounce bit one bypasses the filter, using the raw line level.
// - pull-up bit n turns the weak pull-up of line n on.
// - key-press flags for keys A..H, key A at bit 7.
// - a single read clears the key-press flags.
// - key-press bit reads zero until a press is seen since last clear.
// - line controls apply only while its direction bit is zero.
// - function select bit zero keeps a pin general purpose.
`timescale 1ns/10ps
module gki_core
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] line_level,
  input  wire logic [7:0] line_direction,
  input  wire logic [7:0] row0_function_select,
  input  wire logic [7:0] key_press_event,
  output logic      [7:0] weak_high_enable,
  output logic            irq_n
);
  // ==========================================================
  // control registers
  logic [7:0] irq_enable;
  logic [7:0] irq_polarity;
  logic [7:0] filter_bypass;
  logic [7:0] weak_high;
  logic [7:0] irq_flags;
  logic [7:0] keypress_flags;
  logic [7:0] conditioned;
  logic [7:0] gpio_input;
  logic [7:0] condition;
  logic       flags_read;
  logic       keys_read;
  logic [7:0] clear_mask;
  gki_pkg::gki_rd_state_t rd_state [8];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign flags_read = reg_read && hit(reg_addr, gki_pkg::ADDR_IRQ_FLAGS);
  assign keys_read  = reg_read && hit(reg_addr, gki_pkg::ADDR_KEYPRESS_LOW);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_enable    <= gki_pkg::RESET_BYTE;
      irq_polarity  <= gki_pkg::RESET_BYTE;
      filter_bypass <= gki_pkg::RESET_BYTE;
      weak_high     <= gki_pkg::RESET_BYTE;
    end
    else if (reg_write)
    begin
      if (hit(reg_addr, gki_pkg::ADDR_IRQ_ENABLE))
        irq_enable <= reg_wdata;
      if (hit(reg_addr, gki_pkg::ADDR_IRQ_POLARITY))
        irq_polarity <= reg_wdata;
      if (hit(reg_addr, gki_pkg::ADDR_FILTER_BYP))
        filter_bypass <= reg_wdata;
      if (hit(reg_addr, gki_pkg::ADDR_WEAK_HIGH))
        weak_high <= reg_wdata;
    end
  end

  // ==========================================================
  // input conditioning and per-line condition
  assign gpio_input = ~line_direction & ~row0_function_select;

  genvar n;
  generate
    for (n = 0; n < gki_pkg::LINE_COUNT; n++)
    begin : g_line
      gki_debounce u_deb
      (
        .clk    (clk),
        .reset  (reset),
        .raw    (line_level[n]),
        .bypass (filter_bypass[n]),
        .level  (conditioned[n])
      );
      // matched to polarity then gated by enable and input mode
      assign condition[n] = gpio_input[n] && irq_enable[n] &&
        (conditioned[n] == irq_polarity[n]);

      // two-read clear: first read arms, second read of a set bit clears
      always_ff @(posedge clk)
      begin
        if (reset)
          rd_state[n] <= gki_pkg::GKI_RD_IDLE;
        else if (!irq_flags[n])
          rd_state[n] <= gki_pkg::GKI_RD_IDLE;
        else if (flags_read)
        begin
          case (rd_state[n])
            gki_pkg::GKI_RD_IDLE:  rd_state[n] <= gki_pkg::GKI_RD_ARMED;
            gki_pkg::GKI_RD_ARMED: rd_state[n] <= gki_pkg::GKI_RD_IDLE;
            default:               rd_state[n] <= gki_pkg::GKI_RD_IDLE;
          endcase
        end
      end
      assign clear_mask[n] = flags_read && irq_flags[n] &&
        (rd_state[n] == gki_pkg::GKI_RD_ARMED);
    end
  endgenerate

  // ==========================================================
  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_flags <= gki_pkg::RESET_BYTE;
    else
      irq_flags <= (irq_flags & ~clear_mask) | condition;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      keypress_flags <= gki_pkg::RESET_BYTE;
    else if (keys_read)
      keypress_flags <= key_press_event;
    else
      keypress_flags <= keypress_flags | key_press_event;
  end

  // ==========================================================
  // outputs and read data
  always_ff @(posedge clk)
  begin
    if (reset)
      weak_high_enable <= gki_pkg::RESET_BYTE;
    else
      weak_high_enable <= weak_high & gpio_input;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_n <= 1'b1;
    else
      irq_n <= !(|(irq_flags & irq_enable) || |keypress_flags);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= gki_pkg::RESET_BYTE;
    else if (reg_read)
    begin
      case (reg_addr)
        gki_pkg::ADDR_LEVEL:        reg_rdata <= line_level;
        gki_pkg::ADDR_IRQ_ENABLE:   reg_rdata <= irq_enable;
        gki_pkg::ADDR_IRQ_FLAGS:    reg_rdata <= irq_flags;
        gki_pkg::ADDR_IRQ_POLARITY: reg_rdata <= irq_polarity;
        gki_pkg::ADDR_FILTER_BYP:   reg_rdata <= filter_bypass;
        gki_pkg::ADDR_WEAK_HIGH:    reg_rdata <= weak_high;
        gki_pkg::ADDR_KEYPRESS_LOW: reg_rdata <= keypress_flags;
        default:                    reg_rdata <= gki_pkg::RESET_BYTE;
      endcase
    end
  end

  // ==========================================================
  // checks
  // a line flag is followed through its two reads on line 0; the
  // second read only clears it when the condition has gone away
  sequence s_first_read;
    flags_read && irq_flags[0] &&
      rd_state[0] == gki_pkg::GKI_RD_IDLE;
  endsequence

  sequence s_second_read;
    flags_read && irq_flags[0] && !condition[0] &&
      rd_state[0] == gki_pkg::GKI_RD_ARMED;
  endsequence

  // reads need not be back to back, so the pair may spread out
  sequence s_read_pair;
    s_first_read ##[1:30] s_second_read;
  endsequence

  // ----- two-read clear of the line flags
  a_one_read_keeps: assert property
    (@(posedge clk) disable iff (reset)
     s_first_read |=> irq_flags[0])
    else $error("line flag cleared by a single read");

  a_read_pair_clears: assert property
    (@(posedge clk) disable iff (reset)
     s_read_pair |=> !irq_flags[0])
    else $error("line flag kept after two reads");

  // a reset also drops the flag, so that edge is left out
  a_fall_needs_reads: assert property
    (@(posedge clk) disable iff (reset)
     $fell(irq_flags[0]) && !$past(reset) |->
       $past(flags_read) &&
       $past(rd_state[0]) == gki_pkg::GKI_RD_ARMED)
    else $error("line flag cleared without two reads");

  // ----- setting of the line flags
  a_flag_sets: assert property
    (@(posedge clk) disable iff (reset)
     condition[7] |=> irq_flags[7])
    else $error("line flag did not set");

  a_flag_needs_cause: assert property
    (@(posedge clk) disable iff (reset)
     $rose(irq_flags[5]) |-> $past(condition[5]))
    else $error("line flag set without a condition");

  a_disabled_line: assert property
    (@(posedge clk) disable iff (reset)
     !irq_enable[2] |-> !condition[2])
    else $error("disabled line raised condition");

  a_condition_gate: assert property
    (@(posedge clk) disable iff (reset)
     condition[6] |-> irq_enable[6] && gpio_input[6])
    else $error("condition on a gated line");

  // ----- active level and input conditioning
  a_polarity_low: assert property
    (@(posedge clk) disable iff (reset)
     gpio_input[1] && irq_enable[1] && !irq_polarity[1] &&
       !conditioned[1] |=> irq_flags[1])
    else $error("low level condition missed");

  a_polarity_high: assert property
    (@(posedge clk) disable iff (reset)
     gpio_input[1] && irq_enable[1] && irq_polarity[1] &&
       conditioned[1] |=> irq_flags[1])
    else $error("high level condition missed");

  a_bypass_path: assert property
    (@(posedge clk) disable iff (reset)
     filter_bypass[3] |-> conditioned[3] == line_level[3])
    else $error("bypass not direct");

  // a fresh change of the raw line can never pass the filter at once
  a_filter_holds: assert property
    (@(posedge clk) disable iff (reset)
     !filter_bypass[3] && $changed(line_level[3]) |=>
       filter_bypass[3] || $stable(conditioned[3]))
    else $error("filter passed an unsettled level");

  // ----- key-press flags
  a_key_read_clear: assert property
    (@(posedge clk) disable iff (reset)
     keys_read && key_press_event == 8'h00 |=> keypress_flags == 8'h00)
    else $error("key flags not cleared by read");

  a_key_sticky: assert property
    (@(posedge clk) disable iff (reset)
     key_press_event[7] |=> keypress_flags[7])
    else $error("key A press not flagged");

  a_key_needs_press: assert property
    (@(posedge clk) disable iff (reset)
     $rose(keypress_flags[0]) |-> $past(key_press_event[0]))
    else $error("key flag set without a press");

  // ----- interrupt output
  a_irq_follows: assert property
    (@(posedge clk) disable iff (reset)
     |keypress_flags |=> !irq_n)
    else $error("interrupt not asserted");

  a_line_irq: assert property
    (@(posedge clk) disable iff (reset)
     |(irq_flags & irq_enable) |=> !irq_n)
    else $error("enabled line flag gave no interrupt");

  a_irq_released: assert property
    (@(posedge clk) disable iff (reset)
     !(|(irq_flags & irq_enable)) && !(|keypress_flags) |=> irq_n)
    else $error("interrupt held with nothing pending");

  // ----- pin mode and pull-ups
  a_output_in_mode: assert property
    (@(posedge clk) disable iff (reset)
     line_direction[4] |-> !condition[4])
    else $error("output line raised condition");

  a_keypad_mode: assert property
    (@(posedge clk) disable iff (reset)
     row0_function_select[5] |-> !condition[5])
    else $error("keypad pin raised condition");

  a_pullup_on: assert property
    (@(posedge clk) disable iff (reset)
     weak_high[6] && gpio_input[6] |=> weak_high_enable[6])
    else $error("pull-up not turned on");

  a_pullup_mode: assert property
    (@(posedge clk) disable iff (reset)
     !gpio_input[6] |=> !weak_high_enable[6])
    else $error("pull-up on for a non-input pin");
endmodule

/* File: testbench/gki_pin_model.sv */
// far-side pin model: external drivers, pull-ups and floating lines
`timescale 1ns/10ps
module gki_pin_model
(
  input  wire logic       clk,
  input  wire logic [7:0] weak_high_enable,
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] drive_val,
  output logic      [7:0] line_level
);
  logic [7:0] drift = 8'h00;
  // an undriven line without pull-up wanders, never a steady level
  always @(posedge clk)
    drift <= ~drift;
  // a released line goes to its pull-up if on, else it wanders
  assign line_level = (drive_en & drive_val) |
    (~drive_en & (weak_high_enable | drift));
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the gpio/key interrupt core
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] line_level;
  logic [7:0] dir = 8'h00;
  logic [7:0] fsel = 8'h00;
  logic [7:0] key = 8'h00;
  logic [7:0] weak_high_enable;
  logic       irq_n;
  logic [7:0] drv_en = 8'hff;
  logic [7:0] drv_val = 8'hff;
  logic [7:0] p, m, k, v;
  logic [7:0] rst_addr [5] = '{8'h1b, 8'h1d, 8'h1e, 8'h1f, 8'h20};
  int         n_errors = 0;
  int         comparisons = 0;
  int         seed;

  always #12.5 clk = ~clk;

  gki_core i_gki_core (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .line_level(line_level), .line_direction(dir),
    .row0_function_select(fsel), .key_press_event(key),
    .weak_high_enable(weak_high_enable), .irq_n(irq_n));
  gki_pin_model i_gki_pin_model (.clk(clk),
    .weak_high_enable(weak_high_enable), .drive_en(drv_en),
    .drive_val(drv_val), .line_level(line_level));

  // ==========================================================
  // register access and helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // condition on lines in c for n cycles, then quiet long enough
  // for the filter to settle back
  task automatic pulse(input logic [7:0] c, input int n);
    drv_val = p ^ ~c;
    repeat (n) @(negedge clk);
    drv_val = ~p;
    repeat (50) @(negedge clk);
  endtask
  task automatic clr;
    drv_val = ~p;
    repeat (50) @(negedge clk);
    rd(8'h1c, v);
    rd(8'h1c, v);
  endtask
  // lines that act as gpio inputs: direction input and not keypad
  function automatic logic [7:0] input_mask(input logic [7:0] d,
                                            input logic [7:0] f);
    return ~d & ~f;
  endfunction
  task automatic end_sim;
    $display("TB: %0d errors, %0d checks", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_errors++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'hc8822f57;
    repeat (20) @(negedge clk);
    `CHK("irq_rst", 1'b1, irq_n)
    reset = 1'b0;
    foreach (rst_addr[i])
    begin
      rd(rst_addr[i], v);
      `CHK("rst_val", 8'h00, v)
    end
    wr(8'h1e, 8'hff);
    wr(8'h1b, 8'hff);
    for (int i = 0; i < 5; i++)
    begin
      p = 8'($random(seed));
      m = (i == 0) ? 8'h81 : 8'($random(seed));
      wr(8'h1d, p);
      clr();
      rd(8'h1d, v);
      `CHK("polarity", p, v)
      pulse(m, 3);
      rd(8'h1c, v);
      `CHK("flags", m, v)
      `CHK("irq_on", m == 8'h00, irq_n)
      rd(8'h1c, v);
      `CHK("flags_1rd", m, v)
      rd(8'h1c, v);
      `CHK("flags_2rd", 8'h00, v)
      `CHK("irq_off", 1'b1, irq_n)
    end
    wr(8'h1b, 8'h00);
    drv_val = p;
    repeat (5) @(negedge clk);
    `CHK("irq_masked", 1'b1, irq_n)
    rd(8'h1c, v);
    `CHK("masked_flags", 8'h00, v)
    wr(8'h1b, 8'hff);
    wr(8'h1e, 8'h00);
    clr();
    pulse(8'hff, 20);
    rd(8'h1c, v);
    `CHK("short_glitch", 8'h00, v)
    pulse(8'hff, 60);
    rd(8'h1c, v);
    `CHK("long_hold", 8'hff, v)
    wr(8'h1e, 8'hff);
    clr();
    dir = m;
    pulse(8'hff, 3);
    rd(8'h1c, v);
    `CHK("dir_gate", input_mask(m, 8'h00), v)
    clr();
    dir = 8'h00;
    fsel = m;
    pulse(8'hff, 3);
    rd(8'h1c, v);
    `CHK("fsel_gate", input_mask(8'h00, m), v)
    clr();
    k = 8'($random(seed));
    dir = 8'($random(seed));
    wr(8'h1f, p);
    repeat (2) @(negedge clk);
    `CHK("pullup", p & input_mask(dir, m), weak_high_enable)
    dir = 8'h00;
    fsel = 8'h00;
    drv_en = 8'h00;
    wr(8'h1f, 8'hff);
    repeat (2) @(negedge clk);
    rd(gki_pkg::ADDR_LEVEL, v);
    `CHK("pull_level", 8'hff, v)
    drv_en = 8'hff;
    clr();
    k = k | 8'h80;
    key = k;
    @(negedge clk);
    key = 8'h00;
    repeat (3) @(negedge clk);
    `CHK("irq_key", 1'b0, irq_n)
    rd(8'h20, v);
    `CHK("keys", k, v)
    rd(8'h20, v);
    `CHK("keys_clr", 8'h00, v)
    wr(8'h1c, 8'hff);
    rd(8'h1c, v);
    `CHK("ro_write", 8'h00, v)
    wr(8'h30, 8'hff);
    rd(8'h30, v);
    `CHK("unmapped", 8'h00, v)
    key = 8'h01;
    @(negedge clk);
    key = 8'h00;
    reset = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("irq_mid_rst", 1'b1, irq_n)
    reset = 1'b0;
    rd(gki_pkg::ADDR_IRQ_ENABLE, v);
    `CHK("mid_rst_en", 8'h00, v)
    rd(gki_pkg::ADDR_KEYPRESS_LOW, v);
    `CHK("mid_rst_keys", 8'h00, v)
    end_sim();
  end
endmodule
